// File: src/eau_pkg.sv
package eau_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_OPA     = 8'h04;
  localparam logic [7:0] OFF_OPB     = 8'h08;
  localparam logic [7:0] OFF_OPD     = 8'h0c;
  localparam logic [7:0] OFF_PC      = 8'h10;
  localparam logic [7:0] OFF_OFFSET  = 8'h14;
  localparam logic [7:0] OFF_FLAGS   = 8'h18;
  localparam logic [7:0] OFF_RES_HI  = 8'h1c;
  localparam logic [7:0] OFF_RES_LO  = 8'h20;
  localparam logic [7:0] OFF_RES_DST = 8'h24;
  localparam logic [7:0] OFF_NEW_PC  = 8'h28;
  localparam logic [7:0] OFF_STATUS  = 8'h2c;
  // Control fields
  localparam int CTRL_OP_LSB  = 0;
  localparam int CTRL_REG_LSB = 4;
  localparam int CTRL_GO_BIT  = 8;
  // Flag positions
  localparam int FLAG_N = 3;
  localparam int FLAG_Z = 2;
  localparam int FLAG_V = 1;
  localparam int FLAG_C = 0;
  // Status positions
  localparam int ST_BUSY   = 0;
  localparam int ST_DONE   = 1;
  localparam int ST_BRANCH = 2;
  localparam int ST_WR_HI  = 3;
  localparam int ST_WR_LO  = 4;
  localparam int ST_WR_DST = 5;
  localparam int ST_ODD    = 6;
  // Operation codes
  localparam logic [2:0] OP_DIV        = 3'h0;
  localparam logic [2:0] OP_SHIFT      = 3'h1;
  localparam logic [2:0] OP_SHIFT_PAIR = 3'h2;
  localparam logic [2:0] OP_XOR        = 3'h3;
  localparam logic [2:0] OP_DECR_BR    = 3'h4;
  // Reset values and shift constants
  localparam logic [3:0]  FLAGS_RST  = 4'h0;
  localparam logic [15:0] WORD_RST   = 16'h0000;
  localparam logic [5:0]  SHIFT_BIAS = 6'h20;
  localparam logic [5:0]  CNT_ZERO   = 6'h00;
endpackage : eau_pkg

// File: src/eau_div_if.sv
`timescale 1ns/1ps
interface eau_div_if #(parameter int W = 16);
  logic             start;
  logic [2*W-1:0]   dividend;
  logic [W-1:0]     divisor;
  logic             done;
  logic [2*W-1:0]   quotient;
  logic [W-1:0]     remainder;

  modport ctl (output start, dividend, divisor,
               input  done, quotient, remainder);
  modport div (input  start, dividend, divisor,
               output done, quotient, remainder);
endinterface : eau_div_if

// File: src/eau_shifter.sv
`timescale 1ns/1ps
module eau_shifter #(
  parameter int W = 16
) (
  // Operand and signed count
  input  logic [W-1:0] val,
  input  logic [5:0]   count,
  // Result and flags
  output logic [W-1:0] result,
  output logic         ovf,
  output logic         carry
);
  localparam int EXT = W + 64;

  logic [EXT-1:0] ext;
  logic [EXT-1:0] r;
  logic [5:0]     amt;

  // A bias of 32 turns the signed count into one left shift
  always_comb
  begin
    amt    = count + eau_pkg::SHIFT_BIAS;
    ext    = {{64{val[W-1]}}, val};
    r      = ext << amt;
    result = r[W+31:32];
    ovf    = r[EXT-1:W+32] != {32{r[W+31]}};
    if (count == eau_pkg::CNT_ZERO)
      carry = 1'b0;
    else if (count[5])
      carry = r[31];
    else
      carry = r[W+32];
  end
endmodule : eau_shifter

// File: src/eau_divider.sv
`timescale 1ns/1ps
module eau_divider #(
  parameter int W = 16
) (
  // Clock and reset
  input  logic clk,
  input  logic rst,
  // Request and answer
  eau_div_if.div dv
);
  localparam int CW = $clog2(2*W);

  typedef enum logic {DV_IDLE, DV_RUN} eau_dv_state_t;

  eau_dv_state_t  st_q, st_d;
  logic [CW-1:0]  cnt_q, cnt_d;
  logic [W:0]     rem_q, rem_d;
  logic [2*W-1:0] quo_q, quo_d;
  logic [W-1:0]   den_q, den_d;
  logic           negq_q, negq_d;
  logic           negr_q, negr_d;
  logic           done_q, done_d;
  logic [2*W-1:0] qout_q, qout_d;
  logic [W-1:0]   rout_q, rout_d;
  logic [W:0]     t;

  function automatic logic [2*W-1:0] mag(input logic [2*W-1:0] v);
    return v[2*W-1] ? -v : v;
  endfunction : mag

  // Unsigned restoring divide on magnitudes, signs fixed at the end
  always_comb
  begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    rem_d  = rem_q;
    quo_d  = quo_q;
    den_d  = den_q;
    negq_d = negq_q;
    negr_d = negr_q;
    done_d = 1'b0;
    qout_d = qout_q;
    rout_d = rout_q;
    t      = {rem_q[W-1:0], quo_q[2*W-1]};
    unique case (st_q)
      DV_IDLE:
        if (dv.start)
        begin
          quo_d  = mag(dv.dividend);
          den_d  = W'(mag({{W{dv.divisor[W-1]}}, dv.divisor}));
          rem_d  = '0;
          cnt_d  = '0;
          negq_d = dv.dividend[2*W-1] ^ dv.divisor[W-1];
          negr_d = dv.dividend[2*W-1];
          st_d   = DV_RUN;
        end
      DV_RUN:
      begin
        if (t >= {1'b0, den_q})
        begin
          rem_d = t - {1'b0, den_q};
          quo_d = {quo_q[2*W-2:0], 1'b1};
        end
        else
        begin
          rem_d = t;
          quo_d = {quo_q[2*W-2:0], 1'b0};
        end
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == CW'(2*W-1))
        begin
          st_d   = DV_IDLE;
          done_d = 1'b1;
          qout_d = negq_q ? -quo_d : quo_d;
          rout_d = negr_q ? -rem_d[W-1:0] : rem_d[W-1:0];
        end
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_q   <= DV_IDLE;
      cnt_q  <= '0;
      rem_q  <= '0;
      quo_q  <= '0;
      den_q  <= '0;
      negq_q <= 1'b0;
      negr_q <= 1'b0;
      done_q <= 1'b0;
      qout_q <= '0;
      rout_q <= '0;
    end
    else
    begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      rem_q  <= rem_d;
      quo_q  <= quo_d;
      den_q  <= den_d;
      negq_q <= negq_d;
      negr_q <= negr_d;
      done_q <= done_d;
      qout_q <= qout_d;
      rout_q <= rout_d;
    end
  end

  assign dv.done      = done_q;
  assign dv.quotient  = qout_q;
  assign dv.remainder = rout_q;
endmodule : eau_divider

// File: src/eau_extended_arith.sv
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
// Functional notes
// - Divide 32-bit even:odd register pair by operand; register must be even.
// - Divide sets N from quotient bit 15.
// - Divide sets Z when the full 32-bit quotient is zero.
// - Divide sets C on zero divisor, clears it otherwise.
// - Divide sets V on zero divisor or quotient too wide for 16 bits.
// - Divide stores quotient low half in even register, remainder in odd.
// - Single shift by signed six-bit count, left positive, result back.
// - Single shift: Z on zero result, N from result bit 15.
// - Single shift: V when bits shifted past the result mismatch its sign.
// - Single shift: C is last bit out, cleared for zero count.
// - Combined shift joins register pair as 32 bits, shifts, splits back.
// - Combined shift: Z on zero 32-bit result, N from high bit 15.
// - Combined shift: V when bits shifted past the 32-bit result mismatch its sign.
// - Combined shift: C last high bit out left, low bit out right.
// - XOR register with operand, store at destination, set Z and N.
// - XOR always clears V.
// - Decrement register, write it, branch only if result nonzero.
// - Branch target is PC minus twice the six-bit offset.
module eau_extended_arith (
  // Clock and reset
  input  logic        clk,
  input  logic        rst,
  // APB slave
  input  logic        psel,
  input  logic        penable,
  input  logic        pwrite,
  input  logic [7:0]  paddr,
  input  logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic        pready,
  output logic        pslverr
);
  typedef enum logic {EU_IDLE, EU_DIV} eau_state_t;

  eau_state_t  st_q, st_d;
  logic [2:0]  op_q, op_d;
  logic [2:0]  regnum_q, regnum_d;
  logic [15:0] opa_q, opa_d;
  logic [15:0] opb_q, opb_d;
  logic [15:0] opd_q, opd_d;
  logic [15:0] pc_q, pc_d;
  logic [5:0]  off_q, off_d;
  logic [3:0]  flags_q, flags_d;
  logic [15:0] res_hi_q, res_hi_d;
  logic [15:0] res_lo_q, res_lo_d;
  logic [15:0] res_dst_q, res_dst_d;
  logic [15:0] newpc_q, newpc_d;
  logic [2:0]  wr_q, wr_d;
  logic        branch_q, branch_d;
  logic        done_q, done_d;
  logic        odd_q, odd_d;
  logic [31:0] rd_q, rd_d;
  logic        err_q, err_d;

  logic        wr_acc;
  logic        busy;
  logic        go;
  logic [2:0]  cmd_op;
  logic [2:0]  cmd_reg;
  logic [15:0] sh1_res;
  logic        sh1_v;
  logic        sh1_c;
  logic [31:0] sh2_res;
  logic        sh2_v;
  logic        sh2_c;
  logic [15:0] xor_res;
  logic [15:0] decr_res;
  logic [15:0] pc_tgt;
  logic        div_v;
  logic [31:0] stat;

  eau_div_if #(.W(16)) dv ();

  function automatic logic mapped(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= eau_pkg::OFF_STATUS);
  endfunction : mapped

  assign pready  = 1'b1;
  assign prdata  = rd_q;
  assign pslverr = err_q;
  assign wr_acc  = psel && penable && pwrite;
  assign busy    = st_q != EU_IDLE;
  assign cmd_op  = pwdata[eau_pkg::CTRL_OP_LSB +: 3];
  assign cmd_reg = pwdata[eau_pkg::CTRL_REG_LSB +: 3];
  // Commands during a divide are dropped, not queued
  assign go      = wr_acc && !busy && (paddr == eau_pkg::OFF_CTRL)
                   && pwdata[eau_pkg::CTRL_GO_BIT];

  eau_shifter #(.W(16)) u_sh1 (
    .val    (opa_q),
    .count  (opd_q[5:0]),
    .result (sh1_res),
    .ovf    (sh1_v),
    .carry  (sh1_c)
  );

  eau_shifter #(.W(32)) u_sh2 (
    .val    ({opa_q, opb_q}),
    .count  (opd_q[5:0]),
    .result (sh2_res),
    .ovf    (sh2_v),
    .carry  (sh2_c)
  );

  eau_divider #(.W(16)) u_div (
    .clk (clk),
    .rst (rst),
    .dv  (dv.div)
  );

  assign dv.start    = go && (cmd_op == eau_pkg::OP_DIV) && !cmd_reg[0]
                       && (opd_q != eau_pkg::WORD_RST);
  assign dv.dividend = {opa_q, opb_q};
  assign dv.divisor  = opd_q;
  assign div_v       = dv.quotient[31:16] != {16{dv.quotient[15]}};
  assign xor_res     = opa_q ^ opd_q;
  assign decr_res    = opa_q - 16'h0001;
  assign pc_tgt      = pc_q - {9'h000, off_q, 1'b0};

  // Operand registers, frozen while a divide runs
  always_comb
  begin
    op_d     = op_q;
    regnum_d = regnum_q;
    opa_d    = opa_q;
    opb_d    = opb_q;
    opd_d    = opd_q;
    pc_d     = pc_q;
    off_d    = off_q;
    if (wr_acc && !busy)
    begin
      case (paddr)
        eau_pkg::OFF_CTRL:
        begin
          op_d     = cmd_op;
          regnum_d = cmd_reg;
        end
        eau_pkg::OFF_OPA:    opa_d = pwdata[15:0];
        eau_pkg::OFF_OPB:    opb_d = pwdata[15:0];
        eau_pkg::OFF_OPD:    opd_d = pwdata[15:0];
        eau_pkg::OFF_PC:     pc_d  = pwdata[15:0];
        eau_pkg::OFF_OFFSET: off_d = pwdata[5:0];
        default:             op_d  = op_q;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      op_q     <= eau_pkg::OP_DIV;
      regnum_q <= 3'h0;
      opa_q    <= eau_pkg::WORD_RST;
      opb_q    <= eau_pkg::WORD_RST;
      opd_q    <= eau_pkg::WORD_RST;
      pc_q     <= eau_pkg::WORD_RST;
      off_q    <= 6'h00;
    end
    else
    begin
      op_q     <= op_d;
      regnum_q <= regnum_d;
      opa_q    <= opa_d;
      opb_q    <= opb_d;
      opd_q    <= opd_d;
      pc_q     <= pc_d;
      off_q    <= off_d;
    end
  end

  // Execution and results
  always_comb
  begin
    st_d      = st_q;
    flags_d   = flags_q;
    res_hi_d  = res_hi_q;
    res_lo_d  = res_lo_q;
    res_dst_d = res_dst_q;
    newpc_d   = newpc_q;
    wr_d      = wr_q;
    branch_d  = branch_q;
    done_d    = done_q;
    odd_d     = odd_q;
    if (wr_acc && !busy && (paddr == eau_pkg::OFF_FLAGS))
      flags_d = pwdata[3:0];
    if (go)
    begin
      wr_d     = 3'h0;
      branch_d = 1'b0;
      odd_d    = 1'b0;
      done_d   = 1'b1;
      unique case (cmd_op)
        eau_pkg::OP_DIV:
          if (cmd_reg[0])
            odd_d = 1'b1;
          else if (opd_q == eau_pkg::WORD_RST)
          begin
            flags_d[eau_pkg::FLAG_C] = 1'b1;
            flags_d[eau_pkg::FLAG_V] = 1'b1;
          end
          else
          begin
            done_d = 1'b0;
            st_d   = EU_DIV;
          end
        eau_pkg::OP_SHIFT:
        begin
          res_hi_d = sh1_res;
          wr_d[0]  = 1'b1;
          flags_d  = {sh1_res[15], sh1_res == eau_pkg::WORD_RST,
                      sh1_v, sh1_c};
        end
        eau_pkg::OP_SHIFT_PAIR:
        begin
          res_hi_d = sh2_res[31:16];
          res_lo_d = sh2_res[15:0];
          wr_d     = 3'h3;
          flags_d  = {sh2_res[31], sh2_res == 32'h0000_0000,
                      sh2_v, sh2_c};
        end
        eau_pkg::OP_XOR:
        begin
          res_dst_d = xor_res;
          wr_d[2]   = 1'b1;
          flags_d[eau_pkg::FLAG_N] = xor_res[15];
          flags_d[eau_pkg::FLAG_Z] = xor_res == eau_pkg::WORD_RST;
          flags_d[eau_pkg::FLAG_V] = 1'b0;
        end
        eau_pkg::OP_DECR_BR:
        begin
          res_hi_d = decr_res;
          wr_d[0]  = 1'b1;
          branch_d = decr_res != eau_pkg::WORD_RST;
          newpc_d  = branch_d ? pc_tgt : pc_q;
        end
        default:
          done_d = 1'b1;
      endcase
    end
    if (busy && dv.done)
    begin
      st_d     = EU_IDLE;
      done_d   = 1'b1;
      res_hi_d = dv.quotient[15:0];
      res_lo_d = dv.remainder;
      wr_d     = 3'h3;
      flags_d  = {dv.quotient[15],
                  dv.quotient == 32'h0000_0000,
                  div_v, 1'b0};
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_q      <= EU_IDLE;
      flags_q   <= eau_pkg::FLAGS_RST;
      res_hi_q  <= eau_pkg::WORD_RST;
      res_lo_q  <= eau_pkg::WORD_RST;
      res_dst_q <= eau_pkg::WORD_RST;
      newpc_q   <= eau_pkg::WORD_RST;
      wr_q      <= 3'h0;
      branch_q  <= 1'b0;
      done_q    <= 1'b0;
      odd_q     <= 1'b0;
    end
    else
    begin
      st_q      <= st_d;
      flags_q   <= flags_d;
      res_hi_q  <= res_hi_d;
      res_lo_q  <= res_lo_d;
      res_dst_q <= res_dst_d;
      newpc_q   <= newpc_d;
      wr_q      <= wr_d;
      branch_q  <= branch_d;
      done_q    <= done_d;
      odd_q     <= odd_d;
    end
  end

  // Read data is captured in the setup phase so prdata comes from a flop
  always_comb
  begin
    stat = 32'h0000_0000;
    stat[eau_pkg::ST_BUSY]   = busy;
    stat[eau_pkg::ST_DONE]   = done_q;
    stat[eau_pkg::ST_BRANCH] = branch_q;
    stat[eau_pkg::ST_WR_HI]  = wr_q[0];
    stat[eau_pkg::ST_WR_LO]  = wr_q[1];
    stat[eau_pkg::ST_WR_DST] = wr_q[2];
    stat[eau_pkg::ST_ODD]    = odd_q;
    rd_d  = rd_q;
    err_d = err_q;
    if (psel && !penable)
    begin
      err_d = !mapped(paddr);
      case (paddr)
        eau_pkg::OFF_CTRL:    rd_d = {25'h0, regnum_q, 1'b0, op_q};
        eau_pkg::OFF_OPA:     rd_d = {16'h0000, opa_q};
        eau_pkg::OFF_OPB:     rd_d = {16'h0000, opb_q};
        eau_pkg::OFF_OPD:     rd_d = {16'h0000, opd_q};
        eau_pkg::OFF_PC:      rd_d = {16'h0000, pc_q};
        eau_pkg::OFF_OFFSET:  rd_d = {26'h0, off_q};
        eau_pkg::OFF_FLAGS:   rd_d = {28'h0, flags_q};
        eau_pkg::OFF_RES_HI:  rd_d = {16'h0000, res_hi_q};
        eau_pkg::OFF_RES_LO:  rd_d = {16'h0000, res_lo_q};
        eau_pkg::OFF_RES_DST: rd_d = {16'h0000, res_dst_q};
        eau_pkg::OFF_NEW_PC:  rd_d = {16'h0000, newpc_q};
        eau_pkg::OFF_STATUS:  rd_d = stat;
        default:              rd_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rd_q  <= 32'h0000_0000;
      err_q <= 1'b0;
    end
    else
    begin
      rd_q  <= rd_d;
      err_q <= err_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_div_odd_reg: assert property (
    go && cmd_op == eau_pkg::OP_DIV && cmd_reg[0]
    |=> odd_q && wr_q == 3'h0 && !busy)
    else $error("odd divide register not refused");

  a_div_latency: assert property (
    dv.start |-> ##33 dv.done ##1 (wr_q == 3'h3 && done_q
    && res_hi_q == $past(dv.quotient[15:0])))
    else $error("divide result late or not stored");

  a_div_flags: assert property (
    busy && dv.done |=> flags_q[eau_pkg::FLAG_N] == $past(dv.quotient[15])
    && flags_q[eau_pkg::FLAG_Z] == ($past(dv.quotient) == 32'h0)
    && !flags_q[eau_pkg::FLAG_C]
    && flags_q[eau_pkg::FLAG_V] == $past(div_v))
    else $error("divide flags wrong");

  a_div_by_zero: assert property (
    go && cmd_op == eau_pkg::OP_DIV && !cmd_reg[0] && opd_q == 16'h0000
    |=> flags_q[eau_pkg::FLAG_C] && flags_q[eau_pkg::FLAG_V] && !busy)
    else $error("zero divisor flags wrong");

  a_shift_zero_count: assert property (
    go && cmd_op == eau_pkg::OP_SHIFT && opd_q[5:0] == 6'h00
    |=> res_hi_q == $past(opa_q) && !flags_q[eau_pkg::FLAG_C]
    && !flags_q[eau_pkg::FLAG_V])
    else $error("zero count shift wrong");

  a_shift_right_one: assert property (
    go && cmd_op == eau_pkg::OP_SHIFT && opd_q[5:0] == 6'h3f
    |=> res_hi_q == $past({opa_q[15], opa_q[15:1]})
    && flags_q[eau_pkg::FLAG_C] == $past(opa_q[0])
    && flags_q[eau_pkg::FLAG_N] == res_hi_q[15])
    else $error("right shift by one wrong");

  a_shift_sign_ovf: assert property (
    go && cmd_op == eau_pkg::OP_SHIFT && opd_q[5:0] == 6'h01
    |=> flags_q[eau_pkg::FLAG_V] == $past(opa_q[15] ^ opa_q[14]))
    else $error("shift overflow wrong");

  a_pair_left_one: assert property (
    go && cmd_op == eau_pkg::OP_SHIFT_PAIR && opd_q[5:0] == 6'h01
    |=> {res_hi_q, res_lo_q} == $past({opa_q[14:0], opb_q, 1'b0})
    && flags_q[eau_pkg::FLAG_C] == $past(opa_q[15])
    && flags_q[eau_pkg::FLAG_V] == $past(opa_q[15] ^ opa_q[14]))
    else $error("combined shift wrong");

  a_xor_result: assert property (
    go && cmd_op == eau_pkg::OP_XOR
    |=> res_dst_q == $past(opa_q ^ opd_q) && !flags_q[eau_pkg::FLAG_V]
    && flags_q[eau_pkg::FLAG_C] == $past(flags_q[eau_pkg::FLAG_C]))
    else $error("xor wrong");

  a_decr_branch: assert property (
    go && cmd_op == eau_pkg::OP_DECR_BR
    |=> res_hi_q == $past(opa_q) - 16'h0001
    && branch_q == ($past(opa_q) != 16'h0001)
    && (!branch_q || newpc_q == $past(pc_q) - {9'h0, $past(off_q), 1'b0})
    && flags_q == $past(flags_q))
    else $error("decrement branch wrong");

  c_div_done: cover property (busy && dv.done);
  c_pair_right: cover property (go && cmd_op == eau_pkg::OP_SHIFT_PAIR
                                && opd_q[5]);
  c_decr_taken: cover property (go && cmd_op == eau_pkg::OP_DECR_BR
                                ##1 branch_q);
  c_div_zero: cover property (go && cmd_op == eau_pkg::OP_DIV
                              && opd_q == 16'h0000);
endmodule : eau_extended_arith

// File: test/eau_host_model.sv
`timescale 1ns/1ps
module eau_host_model (
  // Clock
  input  logic        clk,
  // Request side
  output logic        psel,
  output logic        penable,
  output logic        pwrite,
  output logic [7:0]  paddr,
  output logic [31:0] pwdata,
  // Answer side
  input  logic [31:0] prdata,
  input  logic        pready,
  input  logic        pslverr
);
  initial
  begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
  end

  // One transfer; request held until pready is seen at a rising edge
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1)
    begin
      eau_extended_arith_tb.err_count++;
      eau_extended_arith_tb.wrap_up();
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : eau_host_model

// File: test/eau_extended_arith_tb.sv
`timescale 1ns/1ps
module eau_extended_arith_tb;
  logic        clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  int          err_count;
  int          n_compared;

  always #2 clk = ~clk;

  eau_extended_arith DUT (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  eau_host_model u_host (
    .clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  task automatic wrap_up();
    if (err_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up

  task automatic check(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    u_host.xfer(1'b1, a, d, q, e);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] exp, input string nm);
    logic [31:0] q;
    logic        e;
    u_host.xfer(1'b0, a, 32'h0, q, e);
    check(nm, q & m, exp);
  endtask : rd_chk

  // Operands then flags; flags preset shows which ones an op leaves alone
  task automatic load(input logic [15:0] a, b, d, input logic [3:0] f);
    wr(eau_pkg::OFF_OPA, {16'h0, a});
    wr(eau_pkg::OFF_OPB, {16'h0, b});
    wr(eau_pkg::OFF_OPD, {16'h0, d});
    wr(eau_pkg::OFF_FLAGS, {28'h0, f});
  endtask : load

  // Start a command and poll done with a bound, since divide is slow
  task automatic go(input logic [2:0] op, input logic [2:0] r);
    logic [31:0] q;
    logic        e;
    int          n;
    wr(eau_pkg::OFF_CTRL, {23'h0, 1'b1, 1'b0, r, 1'b0, op});
    for (n = 0; n < 60; n++)
    begin
      u_host.xfer(1'b0, eau_pkg::OFF_STATUS, 32'h0, q, e);
      if (q[eau_pkg::ST_DONE] === 1'b1)
        break;
    end
    if (n == 60)
    begin
      err_count++;
      wrap_up();
    end
  endtask : go

  task automatic t_divide();
    load(16'h0000, 16'h0007, 16'h0002, 4'hf);
    go(eau_pkg::OP_DIV, 3'h0);
    rd_chk(eau_pkg::OFF_RES_HI, 32'hffff, 32'h3, "quotient");
    rd_chk(eau_pkg::OFF_RES_LO, 32'hffff, 32'h1, "remainder");
    rd_chk(eau_pkg::OFF_FLAGS, 32'hf, 32'h0, "div flags");
    load(16'h4000, 16'h0000, 16'h0001, 4'h0);
    go(eau_pkg::OP_DIV, 3'h0);
    rd_chk(eau_pkg::OFF_FLAGS, 32'hf, 32'h2, "div wide");
    load(16'h0000, 16'h8000, 16'h0001, 4'h0);
    go(eau_pkg::OP_DIV, 3'h0);
    rd_chk(eau_pkg::OFF_FLAGS, 32'hf, 32'ha, "div 2e15");
    load(16'h0001, 16'h0000, 16'h0000, 4'hc);
    go(eau_pkg::OP_DIV, 3'h0);
    rd_chk(eau_pkg::OFF_FLAGS, 32'hf, 32'hf, "div zero");
    load(16'h0000, 16'h0007, 16'h0002, 4'h0);
    go(eau_pkg::OP_DIV, 3'h1);
    rd_chk(eau_pkg::OFF_STATUS, 32'h40, 32'h40, "odd reg");
  endtask : t_divide

  task automatic t_single();
    load(16'h4001, 16'h0000, 16'h0001, 4'h0);
    go(3'h1, 3'h0);
    rd_chk(eau_pkg::OFF_RES_HI, 32'hffff, 32'h8002, "shl");
    rd_chk(eau_pkg::OFF_FLAGS, 32'hf, 32'ha, "shl flags");
    load(16'h0003, 16'h0000, 16'h003f, 4'h0);
    go(3'h1, 3'h0);
    rd_chk(eau_pkg::OFF_RES_HI, 32'hffff, 32'h1, "shr");
    rd_chk(eau_pkg::OFF_FLAGS, 32'hf, 32'h1, "shr flags");
    load(16'h8000, 16'h0000, 16'h0000, 4'hf);
    go(3'h1, 3'h0);
    rd_chk(eau_pkg::OFF_FLAGS, 32'hf, 32'h8, "sh0 flags");
    load(16'h8000, 16'h0000, 16'h0020, 4'h0);
    go(3'h1, 3'h0);
    rd_chk(eau_pkg::OFF_RES_HI, 32'hffff, 32'hffff, "shr32");
    rd_chk(eau_pkg::OFF_FLAGS, 32'hf, 32'h9, "shr32 flags");
  endtask : t_single

  task automatic t_combined();
    load(16'h0001, 16'h8001, 16'h003f, 4'h0);
    go(3'h2, 3'h0);
    rd_chk(eau_pkg::OFF_RES_HI, 32'hffff, 32'h0, "pair hi");
    rd_chk(eau_pkg::OFF_RES_LO, 32'hffff, 32'hc000, "pair lo");
    rd_chk(eau_pkg::OFF_FLAGS, 32'hf, 32'h1, "pair shr");
    load(16'h4000, 16'h0000, 16'h0001, 4'h0);
    go(3'h2, 3'h0);
    rd_chk(eau_pkg::OFF_FLAGS, 32'hf, 32'ha, "pair shl");
    load(16'h8000, 16'h0000, 16'h0001, 4'h0);
    go(3'h2, 3'h0);
    rd_chk(eau_pkg::OFF_FLAGS, 32'hf, 32'h7, "pair zero");
  endtask : t_combined

  task automatic t_xor();
    load(16'h00f0, 16'h0000, 16'h00f0, 4'hf);
    go(eau_pkg::OP_XOR, 3'h0);
    rd_chk(eau_pkg::OFF_RES_DST, 32'hffff, 32'h0, "xor res");
    rd_chk(eau_pkg::OFF_FLAGS, 32'hf, 32'h5, "xor flags");
    load(16'h8000, 16'h0000, 16'h0001, 4'h0);
    go(eau_pkg::OP_XOR, 3'h0);
    rd_chk(eau_pkg::OFF_RES_DST, 32'hffff, 32'h8001, "xor neg");
    rd_chk(eau_pkg::OFF_FLAGS, 32'hf, 32'h8, "xor n");
    rd_chk(eau_pkg::OFF_STATUS, 32'h3f, 32'h22, "xor status");
  endtask : t_xor

  task automatic t_decrement();
    load(16'h0002, 16'h0000, 16'h0000, 4'hf);
    wr(eau_pkg::OFF_PC, 32'h100);
    wr(eau_pkg::OFF_OFFSET, 32'h3f);
    go(3'h4, 3'h0);
    rd_chk(eau_pkg::OFF_RES_HI, 32'hffff, 32'h1, "dec");
    rd_chk(eau_pkg::OFF_STATUS, 32'h4, 32'h4, "taken");
    rd_chk(eau_pkg::OFF_NEW_PC, 32'hffff, 32'h82, "target");
    rd_chk(eau_pkg::OFF_FLAGS, 32'hf, 32'hf, "dec flags");
    load(16'h0001, 16'h0000, 16'h0000, 4'h0);
    go(3'h4, 3'h0);
    rd_chk(eau_pkg::OFF_STATUS, 32'h4, 32'h0, "not taken");
    rd_chk(eau_pkg::OFF_FLAGS, 32'hf, 32'h0, "dec keep");
  endtask : t_decrement

  task automatic t_unmapped();
    logic [31:0] q;
    logic        e;
    u_host.xfer(1'b0, 8'h30, 32'h0, q, e);
    check("unmapped err", {31'h0, e}, 32'h1);
    check("unmapped data", q, 32'h0);
    go(3'h5, 3'h0);
    rd_chk(eau_pkg::OFF_STATUS, 32'h3f, 32'h2, "no-op status");
  endtask : t_unmapped

  initial
  begin
    clk        = 1'b0;
    rst        = 1'b1;
    err_count  = 0;
    n_compared = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd_chk(eau_pkg::OFF_FLAGS, 32'hf, 32'h0, "reset flags");
    t_divide();
    t_single();
    t_combined();
    t_xor();
    t_decrement();
    t_unmapped();
    wrap_up();
  end
endmodule : eau_extended_arith_tb
